// ---- design/ors_top.sv ----
// Behaviour
// - drive-mode bit resets to 0; software sets 1 for a crystal.
// - reset enables relaxation oscillator and clears reference select.
// - writing reference select 1 hands the PLL reference to the external oscillator.
// - internal/external handover produces no glitch or runt on the reference.
// - oscillator control bits 9..0 hold the relaxation trim.
// - trim field comes up at 512 after reset.
// - each trim step moves the relaxation frequency about 0.1 percent.
// - factory trim is copied into flash option word 1 in the first cycle after reset release.
// - both oscillators are powered up at reset.
// - out of reset the PLL reference is the relaxation oscillator.
`include "ors_params.svh"

module ors_top (
    // clock and reset
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    // ahb-lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // reference sources and factory trim from flash information block
    input wire logic RELAX_CLK_IN,
    input wire logic EXT_CLK_IN,
    input wire logic [9:0] FACTORY_TRIM_IN,
    // oscillator and pll controls
    output logic [9:0] TRIM_OUT,
    output logic DRIVE_MODE_OUT,
    output logic RELAX_EN_OUT,
    output logic OSC_OUT_PIN_EN_OUT,
    output logic REF_CLK_OUT,
    output logic REF_EXT_ACTIVE_OUT
);

    // bus state
    logic rd_pend_ff;
    logic wr_pend_ff;
    logic [7:0] addr_ff;
    logic hready_ff;
    logic [31:0] rdata_ff;
    // software registers
    ors_pkg::ors_trim_type trim_ff;
    logic drive_ff;
    // enables kept as flops so the power outputs need no inverter behind them
    logic relax_en_ff;
    logic osc_out_pin_en_ff;
    logic ref_sel_ff;
    ors_pkg::ors_trim_type flash_opt_ff;
    logic load_done_ff;
    // handover state
    ors_pkg::ors_state_type state_ff;
    ors_pkg::ors_state_type nxt_state;
    logic cur_ext_ff;
    logic tgt_ext_ff;
    logic int_en_ff;
    logic ext_en_ff;
    logic ref_ff;

    // address phase decode; only the low byte of the address matters
    wire accept = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    wire wr_osc = wr_pend_ff & (addr_ff == `ORS_OSC_CTRL_OFS);
    wire wr_pll = wr_pend_ff & (addr_ff == `ORS_PLL_CTRL_OFS);
    wire busy = (state_ff != ors_pkg::ORS_ST_RUN);

    // read mux; unmapped offsets read as zero with an okay response
    wire [31:0] osc_word = {19'h00000, ~osc_out_pin_en_ff, ~relax_en_ff, drive_ff, trim_ff};
    wire [31:0] pll_word = {31'h00000000, ref_sel_ff};
    wire [31:0] opt_word = {22'h000000, flash_opt_ff};
    wire [31:0] st_word = {29'h00000000, load_done_ff, busy, cur_ext_ff};
    wire [31:0] rd_mux = (addr_ff == `ORS_OSC_CTRL_OFS) ? osc_word :
                         (addr_ff == `ORS_PLL_CTRL_OFS) ? pll_word :
                         (addr_ff == `ORS_FLASH_OPT1_OFS) ? opt_word :
                         (addr_ff == `ORS_STATUS_OFS) ? st_word : 32'h00000000;

    // bus sequencing: reads take one wait state so a write just before is seen
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rd_pend_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
            hready_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            rd_pend_ff <= accept & ~HWRITE_IN;
            wr_pend_ff <= accept & HWRITE_IN;
            if (accept) begin
                addr_ff <= HADDR_IN[7:0];
            end
            hready_ff <= ~(accept & ~HWRITE_IN);
            if (rd_pend_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // control registers
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            trim_ff <= `ORS_TRIM_RST;
            drive_ff <= `ORS_DRIVE_RST;
            relax_en_ff <= 1'b1;
            osc_out_pin_en_ff <= 1'b1;
            ref_sel_ff <= `ORS_REF_SEL_RST;
        end else begin
            if (wr_osc) begin
                trim_ff <= HWDATA_IN[`ORS_TRIM_MSB:`ORS_TRIM_LSB];
                drive_ff <= HWDATA_IN[`ORS_DRIVE_BIT];
                relax_en_ff <= ~HWDATA_IN[`ORS_RELAX_PD_BIT];
                osc_out_pin_en_ff <= ~HWDATA_IN[`ORS_OSC_OUT_PIN_PD_BIT];
            end
            if (wr_pll) begin
                ref_sel_ff <= HWDATA_IN[`ORS_REF_SEL_BIT];
            end
        end
    end

    // factory trim capture in the first cycle after release, never under reset
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            load_done_ff <= 1'b0;
            flash_opt_ff <= 10'h000;
        end else if (!load_done_ff) begin
            load_done_ff <= 1'b1;
            flash_opt_ff <= FACTORY_TRIM_IN;
        end
    end

    // handover sequencing; waits on the sampled clock levels, so a source
    // that stays high stalls the switch with busy set
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ors_pkg::ORS_ST_RUN: begin
                if (ref_sel_ff != cur_ext_ff) begin
                    nxt_state = ors_pkg::ORS_ST_STOP_OLD;
                end
            end
            ors_pkg::ORS_ST_STOP_OLD: begin
                if (cur_ext_ff ? ~EXT_CLK_IN : ~RELAX_CLK_IN) begin
                    nxt_state = ors_pkg::ORS_ST_START_NEW;
                end
            end
            ors_pkg::ORS_ST_START_NEW: begin
                if (tgt_ext_ff ? ~EXT_CLK_IN : ~RELAX_CLK_IN) begin
                    nxt_state = ors_pkg::ORS_ST_RUN;
                end
            end
            default: begin
                nxt_state = ors_pkg::ORS_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_ff <= ors_pkg::ORS_ST_RUN;
            cur_ext_ff <= 1'b0;
            tgt_ext_ff <= 1'b0;
            int_en_ff <= 1'b1;
            ext_en_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ors_pkg::ORS_ST_RUN) begin
                tgt_ext_ff <= ref_sel_ff;
            end
            if (state_ff == ors_pkg::ORS_ST_STOP_OLD &&
                nxt_state == ors_pkg::ORS_ST_START_NEW) begin
                int_en_ff <= 1'b0;
                ext_en_ff <= 1'b0;
            end
            if (state_ff == ors_pkg::ORS_ST_START_NEW && nxt_state == ors_pkg::ORS_ST_RUN) begin
                int_en_ff <= ~tgt_ext_ff;
                ext_en_ff <= tgt_ext_ff;
                cur_ext_ff <= tgt_ext_ff;
            end
        end
    end

    // gated reference; the dead gap between gates is the price of no runt
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            ref_ff <= 1'b0;
        end else begin
            ref_ff <= (int_en_ff & RELAX_CLK_IN) | (ext_en_ff & EXT_CLK_IN);
        end
    end

    // outputs, all from flip-flops except the tied HRESP_OUT
    assign HRDATA_OUT = rdata_ff;
    assign HREADYOUT_OUT = hready_ff;
    assign HRESP_OUT = 1'b0; // okay only; tied response, no state behind it
    assign TRIM_OUT = trim_ff;
    assign DRIVE_MODE_OUT = drive_ff;
    // power enables come from their own flops; the register shows their inverse
    assign RELAX_EN_OUT = relax_en_ff;
    assign OSC_OUT_PIN_EN_OUT = osc_out_pin_en_ff;
    assign REF_CLK_OUT = ref_ff;
    assign REF_EXT_ACTIVE_OUT = cur_ext_ff;

    // checks
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!ARST_N_IN);

    // reset defaults, seen in the first cycle after release
    a_reset_defaults: assert property (!load_done_ff |->
        trim_ff == 10'h200 && !drive_ff && !ref_sel_ff)
        else $error("reset defaults wrong");
    a_drive_reset: assert property (!load_done_ff |-> DRIVE_MODE_OUT == 1'b0)
        else $error("drive mode not zero at reset");
    a_both_powered: assert property (!load_done_ff |-> RELAX_EN_OUT && OSC_OUT_PIN_EN_OUT)
        else $error("oscillators not powered at reset");
    a_int_default: assert property (!load_done_ff |-> int_en_ff && !cur_ext_ff)
        else $error("internal reference not default");
    a_factory_copy: assert property ($rose(load_done_ff) |->
        flash_opt_ff == $past(FACTORY_TRIM_IN))
        else $error("factory trim not copied");
    a_trim_write: assert property (wr_osc |=> TRIM_OUT == $past(HWDATA_IN[9:0]))
        else $error("trim write lost");
    a_ext_running: assert property (state_ff == ors_pkg::ORS_ST_RUN && cur_ext_ff |->
        ext_en_ff && !int_en_ff)
        else $error("external reference not gated on");
    a_no_overlap: assert property (!(int_en_ff && ext_en_ff))
        else $error("both gates open");
    // gate edges only where the source was sampled low; also the read wait state
    a_stop_low: assert property ($fell(int_en_ff) |-> !$past(RELAX_CLK_IN))
        else $error("relaxation gate closed while high");
    a_start_low: assert property ($rose(ext_en_ff) |-> !$past(EXT_CLK_IN) &&
        $past(state_ff) == ors_pkg::ORS_ST_START_NEW)
        else $error("external gate opened while high");
    a_read_wait: assert property (accept && !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
        else $error("read wait state wrong");
    a_ext_stop_low: assert property ($fell(ext_en_ff) |-> !$past(EXT_CLK_IN))
        else $error("external gate closed while high");
    a_int_start_low: assert property ($rose(int_en_ff) |-> !$past(RELAX_CLK_IN) &&
        $past(state_ff) == ors_pkg::ORS_ST_START_NEW)
        else $error("relaxation gate opened while high");

    // register writes land on the next edge and nothing else moves them
    a_drive_write: assert property (wr_osc |=>
        DRIVE_MODE_OUT == $past(HWDATA_IN[`ORS_DRIVE_BIT]))
        else $error("drive mode write lost");
    a_trim_hold: assert property (!wr_osc |=> $stable(TRIM_OUT))
        else $error("trim changed without a write");
    a_sel_write: assert property (wr_pll |=>
        ref_sel_ff == $past(HWDATA_IN[`ORS_REF_SEL_BIT]))
        else $error("reference select write lost");
    a_opt_stable: assert property (load_done_ff |=> $stable(flash_opt_ff))
        else $error("factory trim copy changed after load");

    // handover sequencing and the gated reference
    a_leave_run: assert property (!busy && ref_sel_ff != cur_ext_ff |=>
        state_ff == ors_pkg::ORS_ST_STOP_OLD)
        else $error("handover did not start");
    a_tgt_hold: assert property (busy |=> $stable(tgt_ext_ff))
        else $error("target changed mid handover");
    a_int_follows: assert property (int_en_ff && !ext_en_ff |=>
        REF_CLK_OUT == $past(RELAX_CLK_IN))
        else $error("reference does not follow relaxation source");
    a_ext_follows: assert property (ext_en_ff && !int_en_ff |=>
        REF_CLK_OUT == $past(EXT_CLK_IN))
        else $error("reference does not follow external source");
    a_gap_low: assert property (!int_en_ff && !ext_en_ff |=> !REF_CLK_OUT)
        else $error("reference high while both gates closed");

    // bus answers
    a_write_no_wait: assert property (accept && HWRITE_IN |=> HREADYOUT_OUT)
        else $error("write inserted a wait state");
    a_read_osc: assert property (rd_pend_ff && addr_ff == `ORS_OSC_CTRL_OFS |=>
        HRDATA_OUT[`ORS_TRIM_MSB:`ORS_TRIM_LSB] == $past(trim_ff))
        else $error("trim read back wrong");
    a_read_pll: assert property (rd_pend_ff && addr_ff == `ORS_PLL_CTRL_OFS |=>
        HRDATA_OUT == {31'h00000000, $past(ref_sel_ff)})
        else $error("reference select read back wrong");
    a_read_ext_flag: assert property (rd_pend_ff && addr_ff == `ORS_STATUS_OFS |=>
        HRDATA_OUT[`ORS_ST_EXT_BIT] == $past(REF_EXT_ACTIVE_OUT))
        else $error("external active flag read back wrong");

    c_switch_ext: cover property ($rose(cur_ext_ff));
    c_switch_int: cover property ($fell(cur_ext_ff));
    c_trim_write: cover property (wr_osc);
    c_read_back: cover property (rd_pend_ff && addr_ff == `ORS_FLASH_OPT1_OFS);
    c_busy_read: cover property (rd_pend_ff && addr_ff == `ORS_STATUS_OFS && busy);

endmodule : ors_top

// ---- design/ors_params.svh ----
`ifndef ORS_PARAMS_SVH
`define ORS_PARAMS_SVH

// register byte offsets
`define ORS_OSC_CTRL_OFS 8'h00
`define ORS_PLL_CTRL_OFS 8'h04
`define ORS_FLASH_OPT1_OFS 8'h08
`define ORS_STATUS_OFS 8'h0C

// osc_control_reg fields
`define ORS_TRIM_LSB 0
`define ORS_TRIM_MSB 9
`define ORS_DRIVE_BIT 10
`define ORS_RELAX_PD_BIT 11
`define ORS_OSC_OUT_PIN_PD_BIT 12

// pll_control_reg fields
`define ORS_REF_SEL_BIT 0

// status register fields
`define ORS_ST_EXT_BIT 0
`define ORS_ST_BUSY_BIT 1
`define ORS_ST_LOADED_BIT 2

// reset values
`define ORS_TRIM_RST 10'h200
`define ORS_DRIVE_RST 1'h0
`define ORS_REF_SEL_RST 1'h0

`endif

// ---- design/ors_pkg.sv ----
package ors_pkg;

    // reference handover states, one-hot
    typedef enum logic [2:0] {
        ORS_ST_RUN = 3'h1,
        ORS_ST_STOP_OLD = 3'h2,
        ORS_ST_START_NEW = 3'h4
    } ors_state_type;

    typedef logic [9:0] ors_trim_type;

endpackage : ors_pkg

// ---- sim/ors_osc_model.sv ----
module ors_osc_model #(
    parameter int HALF_NS = 40,
    parameter int OFS_NS = 3
) (
    // power control from the block
    input wire logic en_in,
    // oscillator output
    output logic clk_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // a powered-down oscillator stands still low instead of running free
    // runs only when powered
    initial begin
        clk_out = 1'b0;
        #OFS_NS;
        forever begin
            #HALF_NS;
            clk_out = (en_in === 1'b1) ? ~clk_out : 1'b0;
        end
    end
endmodule : ors_osc_model

// ---- sim/ors_top_test.sv ----
module ors_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] FTRIM = 10'h1A5;
    logic clk, arst_n, hsel, hwrite, hready, hresp;
    logic relax_en, osc_out_pin_en, relax_clk, ext_clk, ref_clk, ref_ext, drive, armed, prev;
    logic [1:0] htrans;
    logic [9:0] trim;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int run = 8;

    ors_top dut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .RELAX_CLK_IN(relax_clk), .EXT_CLK_IN(ext_clk), .FACTORY_TRIM_IN(FTRIM),
        .TRIM_OUT(trim), .DRIVE_MODE_OUT(drive), .RELAX_EN_OUT(relax_en),
        .OSC_OUT_PIN_EN_OUT(osc_out_pin_en), .REF_CLK_OUT(ref_clk), .REF_EXT_ACTIVE_OUT(ref_ext));
    ors_osc_model #(.HALF_NS(40), .OFS_NS(3)) relax_osc (.en_in(relax_en), .clk_out(relax_clk));
    ors_osc_model #(.HALF_NS(55), .OFS_NS(7)) ext_osc (.en_in(osc_out_pin_en), .clk_out(ext_clk));

    task summarize();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one single ahb-lite transfer; waits on hready, never on a fixed count
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : xfer

    // reads status until the external-active flag matches, bounded
    task wait_ext(input logic want);
        for (int i = 0; i < 60; i++) begin
            xfer(1'b0, 32'h0C, 32'h0);
            if (rd[0] === want) break;
        end
    endtask : wait_ext

    // free-running bench clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard: running out counts as a mismatch and goes to the report
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // reference run-length watch: a runt shows as a short run
    always @(posedge clk) begin
        prev <= ref_clk;
        if (armed !== 1'b1) begin
            run <= 8;
        end else if (ref_clk !== prev) begin
            chk("ref_run_ok", {31'h0, run >= 4}, 32'h1);
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end

    // main sequence
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        armed = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        xfer(1'b0, 32'h00, 32'h0);
        chk("osc_ctrl_rst", rd, 32'h200);
        chk("trim_rst", {22'h0, trim}, 32'h200);
        chk("drive_rst", {31'h0, drive}, 32'h0);
        chk("powered", {30'h0, relax_en, osc_out_pin_en}, 32'h3);
        chk("ext_rst", {31'h0, ref_ext}, 32'h0);
        xfer(1'b0, 32'h04, 32'h0);
        chk("pll_ctrl_rst", rd, 32'h0);
        xfer(1'b0, 32'h0C, 32'h0);
        chk("status_rst", rd, 32'h4);
        xfer(1'b0, 32'h08, 32'h0);
        chk("flash_opt1", rd, {22'h0, FTRIM});
        armed <= 1'b1;
        // boot code copies the factory trim, then extreme field values
        xfer(1'b1, 32'h00, rd);
        @(posedge clk);
        chk("trim_copy", {22'h0, trim}, {22'h0, FTRIM});
        xfer(1'b1, 32'h00, 32'h7FF);
        xfer(1'b0, 32'h00, 32'h0);
        chk("osc_ctrl_rb", rd, 32'h7FF);
        chk("drive_osc_out_pin", {31'h0, drive}, 32'h1);
        xfer(1'b1, 32'h00, 32'h0);
        @(posedge clk);
        chk("trim_min", {21'h0, drive, trim}, 32'h0);
        xfer(1'b0, 32'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        // handover to the external source and back, both sources running
        xfer(1'b1, 32'h04, 32'h1);
        xfer(1'b0, 32'h0C, 32'h0);
        chk("busy_to_ext", rd, 32'h6);
        wait_ext(1'b1);
        chk("ext_active", {31'h0, ref_ext}, 32'h1);
        repeat (60) @(posedge clk);
        xfer(1'b1, 32'h04, 32'h0);
        xfer(1'b0, 32'h0C, 32'h0);
        chk("busy_to_int", rd, 32'h7);
        wait_ext(1'b0);
        chk("relax_active", {31'h0, ref_ext}, 32'h0);
        repeat (60) @(posedge clk);
        // unused crystal powered down
        xfer(1'b1, 32'h00, 32'h1000);
        @(posedge clk);
        chk("osc_out_pin_pd", {30'h0, relax_en, osc_out_pin_en}, 32'h2);
        summarize();
    end
endmodule : ors_top_test
